// [hw/duhbp_device.sv]
// What this block does
// - address lines pick the channel register
// - bytes cross an eight-bit two-way bus
// - read strobe fall fetches and drives byte
// - host captures read byte at strobe rise
// - write strobe rise loads the bus byte
// - channel opens a cycle and drives only while selected
// - two independent channels with own registers
// - modem bit 3 drives irq and port 2
// - modem bit 3 clear after reset
// - transmit ready low reflects transmit fifo
// - receive ready low reflects receive fifo
// - 64-byte fifos in each direction
`timescale 1ns/10ps
`include "duhbp_defines.svh"

module duhbp_chan (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // host bus, as seen by this channel
  input  wire logic       sel_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] rd_data_o,
  output logic            rd_oe_o,
  // status pins
  output logic            irq_o,
  output logic            irq_oe_o,
  output logic            gp_out2_n_o,
  output logic            tx_ready_n_o,
  output logic            rx_ready_n_o,
  // user side: transmit fifo drain, receive fifo fill
  output logic      [7:0] tx_data_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  output logic            rx_ready_o
);
  logic [7:0]                tx_mem [`DUHBP_FIFO_DEPTH];
  logic [7:0]                rx_mem [`DUHBP_FIFO_DEPTH];
  logic [`DUHBP_PTR_W-1:0]   tx_wp, tx_rp, rx_wp, rx_rp;
  logic [`DUHBP_PTR_W-1:0]   next_tx_wp, next_tx_rp, next_rx_wp, next_rx_rp;
  logic [`DUHBP_CNT_W-1:0]   tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
  logic                      rd_q, wr_q, rd_act, wr_act;
  logic                      next_rd_act, next_wr_act;
  logic [2:0]                rd_addr, wr_addr, next_rd_addr, next_wr_addr;
  logic [7:0]                rd_byte, wr_byte, next_rd_byte, next_wr_byte;
  logic [7:0]                modem_control_reg, scratch, next_mcr, next_scratch;
  logic [1:0]                ien, next_ien;
  logic                      rd_fall, rd_rise, wr_fall, wr_rise;
  logic                      tx_push, tx_pop, rx_push, rx_pop;
  logic                      tx_empty, tx_full, rx_empty, rx_full;
  logic [7:0]                reg_view;

  assign tx_empty = (tx_cnt == '0);
  assign rx_empty = (rx_cnt == '0);
  assign tx_full  = (tx_cnt == `DUHBP_CNT_W'(`DUHBP_FIFO_DEPTH));
  assign rx_full  = (rx_cnt == `DUHBP_CNT_W'(`DUHBP_FIFO_DEPTH));

  // strobe edges; an unselected channel never opens a cycle
  assign rd_fall = sel_i & rd_q & ~rd_n_i;
  assign wr_fall = sel_i & wr_q & ~wr_n_i;
  assign rd_rise = rd_act & rd_n_i;
  assign wr_rise = wr_act & wr_n_i;

  // register view, decoded from the live address lines and sampled into rd_byte at the read fall
  always_comb begin
    reg_view = 8'h00;
    unique case (addr_i)
      `DUHBP_OFS_HOLD:     reg_view = rx_empty ? 8'h00 : rx_mem[rx_rp];
      `DUHBP_OFS_INT_EN:   reg_view = {6'h00, ien};
      `DUHBP_OFS_TX_LEVEL: reg_view = {1'b0, tx_cnt};
      `DUHBP_OFS_RX_LEVEL: reg_view = {1'b0, rx_cnt};
      `DUHBP_OFS_MODEM:    reg_view = modem_control_reg;
      `DUHBP_OFS_STATUS: begin
        reg_view[`DUHBP_ST_RX_AVAIL] = ~rx_empty;
        reg_view[`DUHBP_ST_TX_ROOM]  = ~tx_full;
        reg_view[`DUHBP_ST_TX_EMPTY] = tx_empty;
      end
      `DUHBP_OFS_SCRATCH:  reg_view = scratch;
      default:             reg_view = 8'h00;
    endcase
  end

  // fifo traffic; a write to a full fifo and a read of an empty one are dropped
  assign tx_push = wr_rise & (wr_addr == `DUHBP_OFS_HOLD) & ~tx_full;
  assign tx_pop  = tx_valid_o & tx_ready_i;
  assign rx_push = rx_valid_i & ~rx_full;
  // pop only after the host has taken the byte at the strobe rise
  assign rx_pop  = rd_rise & (rd_addr == `DUHBP_OFS_HOLD) & ~rx_empty;

  always_comb begin
    next_tx_wp  = tx_push ? tx_wp + 1'b1 : tx_wp;
    next_tx_rp  = tx_pop ? tx_rp + 1'b1 : tx_rp;
    next_rx_wp  = rx_push ? rx_wp + 1'b1 : rx_wp;
    next_rx_rp  = rx_pop ? rx_rp + 1'b1 : rx_rp;
    next_tx_cnt = tx_cnt + `DUHBP_CNT_W'(tx_push) - `DUHBP_CNT_W'(tx_pop);
    next_rx_cnt = rx_cnt + `DUHBP_CNT_W'(rx_push) - `DUHBP_CNT_W'(rx_pop);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      rx_wp  <= '0;
      rx_rp  <= '0;
      tx_cnt <= '0;
      rx_cnt <= '0;
    end else begin
      tx_wp  <= next_tx_wp;
      tx_rp  <= next_tx_rp;
      rx_wp  <= next_rx_wp;
      rx_rp  <= next_rx_rp;
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
    end
  end

  // storage needs no reset; occupancy is carried by the counts
  always_ff @(posedge mclk_i) begin
    if (tx_push) begin
      tx_mem[tx_wp] <= wr_byte;
    end
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_data_i;
    end
  end

  // bus cycle state and the software registers
  always_comb begin
    next_rd_act  = rd_act;
    next_rd_addr = rd_addr;
    next_rd_byte = rd_byte;
    next_wr_act  = wr_act;
    next_wr_addr = wr_addr;
    next_wr_byte = wr_byte;
    next_mcr     = modem_control_reg;
    next_ien     = ien;
    next_scratch = scratch;
    if (rd_fall) begin
      next_rd_act  = 1'b1;
      next_rd_addr = addr_i;
      next_rd_byte = reg_view;
    end else if (rd_rise) begin
      next_rd_act = 1'b0;
    end
    if (wr_fall) begin
      next_wr_act  = 1'b1;
      next_wr_addr = addr_i;
    end else if (wr_rise) begin
      next_wr_act = 1'b0;
    end
    // track the bus while the strobe is low; the last low-cycle byte is kept
    if (wr_fall || (wr_act && !wr_n_i)) begin
      next_wr_byte = data_i;
    end
    if (wr_rise) begin
      unique case (wr_addr)
        `DUHBP_OFS_INT_EN:  next_ien = wr_byte[1:0];
        `DUHBP_OFS_MODEM:   next_mcr = wr_byte;
        `DUHBP_OFS_SCRATCH: next_scratch = wr_byte;
        default:            next_ien = ien;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_q    <= 1'b1;
      wr_q    <= 1'b1;
      rd_act  <= 1'b0;
      wr_act  <= 1'b0;
      rd_addr <= '0;
      wr_addr <= '0;
      rd_byte <= 8'h00;
      wr_byte <= 8'h00;
      modem_control_reg     <= `DUHBP_MCR_RESET;
      ien     <= `DUHBP_IEN_RESET;
      scratch <= `DUHBP_SCR_RESET;
    end else begin
      rd_q    <= rd_n_i;
      wr_q    <= wr_n_i;
      rd_act  <= next_rd_act;
      wr_act  <= next_wr_act;
      rd_addr <= next_rd_addr;
      wr_addr <= next_wr_addr;
      rd_byte <= next_rd_byte;
      wr_byte <= next_wr_byte;
      modem_control_reg     <= next_mcr;
      ien     <= next_ien;
      scratch <= next_scratch;
    end
  end

  // drive only inside an opened read cycle, while still selected
  assign rd_oe_o   = rd_act & ~rd_n_i & sel_i;
  assign rd_data_o = rd_byte;

  assign irq_o       = (ien[`DUHBP_IEN_RX] & ~rx_empty) | (ien[`DUHBP_IEN_TX] & tx_empty);
  assign irq_oe_o    = modem_control_reg[`DUHBP_MCR_IRQ_DRV];
  assign gp_out2_n_o = ~modem_control_reg[`DUHBP_MCR_IRQ_DRV];
  assign tx_ready_n_o = tx_full;
  assign rx_ready_n_o = rx_empty;

  assign tx_valid_o = ~tx_empty;
  assign tx_data_o  = tx_mem[tx_rp];
  assign rx_ready_o = ~rx_full;
endmodule : duhbp_chan

module duhbp_device (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // host bus
  duhbp_if.dev            bus,
  // user side, index 0 is channel a, 1 is channel b
  output logic [1:0][7:0] tx_data_o,
  output logic [1:0]      tx_valid_o,
  input  wire logic [1:0] tx_ready_i,
  input  wire logic [1:0][7:0] rx_data_i,
  input  wire logic [1:0] rx_valid_i,
  output logic [1:0]      rx_ready_o
);
  logic [1:0]      sel, rd_oe, irq, irq_oe, gp2_n, txr_n, rxr_n;
  logic [1:0][7:0] rd_data;

  assign sel = {~bus.chan_b_select_n, ~bus.chan_a_select_n};

  for (genvar c = 0; c < 2; c++) begin : g_chan
    duhbp_chan u_chan (
      .mclk_i       (mclk_i),
      .rst_i        (rst_i),
      .sel_i        (sel[c]),
      .rd_n_i       (bus.read_strobe_n),
      .wr_n_i       (bus.write_strobe_n),
      .addr_i       (bus.addr),
      .data_i       (bus.data),
      .rd_data_o    (rd_data[c]),
      .rd_oe_o      (rd_oe[c]),
      .irq_o        (irq[c]),
      .irq_oe_o     (irq_oe[c]),
      .gp_out2_n_o  (gp2_n[c]),
      .tx_ready_n_o (txr_n[c]),
      .rx_ready_n_o (rxr_n[c]),
      .tx_data_o    (tx_data_o[c]),
      .tx_valid_o   (tx_valid_o[c]),
      .tx_ready_i   (tx_ready_i[c]),
      .rx_data_i    (rx_data_i[c]),
      .rx_valid_i   (rx_valid_i[c]),
      .rx_ready_o   (rx_ready_o[c])
    );
  end

  // both selected at once is a host fault; channel a wins the bus
  assign bus.data_d2h    = rd_oe[0] ? rd_data[0] : rd_data[1];
  assign bus.data_d2h_oe = |rd_oe;

  assign bus.irq_chan_a_drv    = irq[0];
  assign bus.irq_chan_a_oe     = irq_oe[0];
  assign bus.irq_chan_b_drv    = irq[1];
  assign bus.irq_chan_b_oe     = irq_oe[1];
  assign bus.gp_out2_chan_a_n  = gp2_n[0];
  assign bus.gp_out2_chan_b_n  = gp2_n[1];
  assign bus.tx_ready_chan_a_n = txr_n[0];
  assign bus.tx_ready_chan_b_n = txr_n[1];
  assign bus.rx_ready_chan_a_n = rxr_n[0];
  assign bus.rx_ready_chan_b_n = rxr_n[1];
endmodule : duhbp_device

// [hw/duhbp_defines.svh]
`ifndef DUHBP_DEFINES_SVH
`define DUHBP_DEFINES_SVH

// register offsets within one channel
`define DUHBP_OFS_HOLD      3'h0
`define DUHBP_OFS_INT_EN    3'h1
`define DUHBP_OFS_TX_LEVEL  3'h2
`define DUHBP_OFS_RX_LEVEL  3'h3
`define DUHBP_OFS_MODEM     3'h4
`define DUHBP_OFS_STATUS    3'h5
`define DUHBP_OFS_SCRATCH   3'h7

// field positions
`define DUHBP_MCR_IRQ_DRV   3
`define DUHBP_IEN_RX        0
`define DUHBP_IEN_TX        1
`define DUHBP_ST_RX_AVAIL   0
`define DUHBP_ST_TX_ROOM    5
`define DUHBP_ST_TX_EMPTY   6

// reset values
`define DUHBP_MCR_RESET     8'h00
`define DUHBP_IEN_RESET     2'h0
`define DUHBP_SCR_RESET     8'h00
`define DUHBP_BUS_IDLE      8'hFF

// fifo geometry
`define DUHBP_FIFO_DEPTH    64
`define DUHBP_PTR_W         6
`define DUHBP_CNT_W         7

// strobe timing of the host end
`define DUHBP_CLK_NS        20
`define DUHBP_STROBE_NS     60
`define DUHBP_STROBE_CYC    ((`DUHBP_STROBE_NS + `DUHBP_CLK_NS - 1) / `DUHBP_CLK_NS)

`endif

// [hw/duhbp_pkg.sv]
package duhbp_pkg;
  typedef logic [2:0] duhbp_addr_type;
  typedef logic [7:0] duhbp_byte_type;
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_SETUP,
    HS_STROBE,
    HS_RECOVER
  } duhbp_hstate_type;
endpackage : duhbp_pkg

// [hw/duhbp_if.sv]
`timescale 1ns/10ps
interface duhbp_if;
  logic [2:0] addr;
  logic [7:0] data_h2d;
  logic       data_h2d_oe;
  logic [7:0] data_d2h;
  logic       data_d2h_oe;
  logic [7:0] data;
  logic       chan_a_select_n;
  logic       chan_b_select_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       irq_chan_a_drv;
  logic       irq_chan_a_oe;
  logic       irq_chan_b_drv;
  logic       irq_chan_b_oe;
  logic       irq_out_chan_a;
  logic       irq_out_chan_b;
  logic       gp_out2_chan_a_n;
  logic       gp_out2_chan_b_n;
  logic       tx_ready_chan_a_n;
  logic       tx_ready_chan_b_n;
  logic       rx_ready_chan_a_n;
  logic       rx_ready_chan_b_n;

  // board pull-up on the data bus, pull-down on the interrupt lines
  assign data = data_d2h_oe ? data_d2h : (data_h2d_oe ? data_h2d : 8'hFF);
  assign irq_out_chan_a = irq_chan_a_oe ? irq_chan_a_drv : 1'b0;
  assign irq_out_chan_b = irq_chan_b_oe ? irq_chan_b_drv : 1'b0;

  modport dev (
    input  addr, data, chan_a_select_n, chan_b_select_n, read_strobe_n, write_strobe_n,
    output data_d2h, data_d2h_oe, irq_chan_a_drv, irq_chan_a_oe, irq_chan_b_drv,
    output irq_chan_b_oe, gp_out2_chan_a_n, gp_out2_chan_b_n,
    output tx_ready_chan_a_n, tx_ready_chan_b_n, rx_ready_chan_a_n, rx_ready_chan_b_n
  );
  modport host (
    output addr, data_h2d, data_h2d_oe, chan_a_select_n, chan_b_select_n,
    output read_strobe_n, write_strobe_n,
    input  data, irq_out_chan_a, irq_out_chan_b, gp_out2_chan_a_n, gp_out2_chan_b_n,
    input  tx_ready_chan_a_n, tx_ready_chan_b_n, rx_ready_chan_a_n, rx_ready_chan_b_n
  );
endinterface : duhbp_if

// [hw/duhbp_host.sv]
`timescale 1ns/10ps
`include "duhbp_defines.svh"

module duhbp_host (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // command port
  input  wire logic       req_i,
  input  wire logic       we_i,
  input  wire logic       chan_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic            busy_o,
  output logic            done_o,
  output logic      [7:0] rdata_o,
  // device bus
  duhbp_if.host           bus
);
  duhbp_pkg::duhbp_hstate_type state, next_state;
  logic                        we, chan, next_we, next_chan;
  logic [2:0]                  addr, next_addr;
  logic [7:0]                  wbyte, next_wbyte, rbyte, next_rbyte;
  logic [1:0]                  cnt, next_cnt;
  logic                        done, next_done;

  always_comb begin
    next_state = state;
    next_we    = we;
    next_chan  = chan;
    next_addr  = addr;
    next_wbyte = wbyte;
    next_rbyte = rbyte;
    next_cnt   = cnt;
    next_done  = 1'b0;
    unique case (state)
      duhbp_pkg::HS_IDLE: begin
        if (req_i) begin
          next_we    = we_i;
          next_chan  = chan_i;
          next_addr  = addr_i;
          next_wbyte = wdata_i;
          next_state = duhbp_pkg::HS_SETUP;
        end
      end
      duhbp_pkg::HS_SETUP: begin
        next_cnt   = '0;
        next_state = duhbp_pkg::HS_STROBE;
      end
      duhbp_pkg::HS_STROBE: begin
        next_cnt = cnt + 1'b1;
        if (cnt == 2'(`DUHBP_STROBE_CYC - 1)) begin
          // sampled in the last low cycle, i.e. at the strobe's rise
          if (!we) begin
            next_rbyte = bus.data;
          end
          next_state = duhbp_pkg::HS_RECOVER;
        end
      end
      duhbp_pkg::HS_RECOVER: begin
        next_done  = 1'b1;
        next_state = duhbp_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= duhbp_pkg::HS_IDLE;
      we    <= 1'b0;
      chan  <= 1'b0;
      addr  <= '0;
      wbyte <= 8'h00;
      rbyte <= 8'h00;
      cnt   <= '0;
      done  <= 1'b0;
    end else begin
      state <= next_state;
      we    <= next_we;
      chan  <= next_chan;
      addr  <= next_addr;
      wbyte <= next_wbyte;
      rbyte <= next_rbyte;
      cnt   <= next_cnt;
      done  <= next_done;
    end
  end

  logic active;
  assign active = (state != duhbp_pkg::HS_IDLE);

  // select and data held one cycle past the strobe rise
  assign bus.chan_a_select_n = ~(active & ~chan);
  assign bus.chan_b_select_n = ~(active & chan);
  assign bus.addr            = addr;
  assign bus.read_strobe_n   = ~((state == duhbp_pkg::HS_STROBE) & ~we);
  assign bus.write_strobe_n  = ~((state == duhbp_pkg::HS_STROBE) & we);
  assign bus.data_h2d        = wbyte;
  assign bus.data_h2d_oe     = active & we;

  assign busy_o  = active;
  assign done_o  = done;
  assign rdata_o = rbyte;
endmodule : duhbp_host

// [tb/duhbp_assertions.sv]
`timescale 1ns/10ps
module duhbp_assertions (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_i,
  // data bus
  input wire logic [7:0] data_d2h,
  input wire logic       data_d2h_oe,
  input wire logic       data_h2d_oe,
  // selects and strobes
  input wire logic       chan_a_select_n,
  input wire logic       chan_b_select_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  // status pins
  input wire logic       irq_chan_a_oe,
  input wire logic       irq_chan_b_oe,
  input wire logic       gp_out2_chan_a_n,
  input wire logic       gp_out2_chan_b_n,
  input wire logic       tx_ready_chan_a_n,
  input wire logic       tx_ready_chan_b_n,
  input wire logic       rx_ready_chan_a_n,
  input wire logic       rx_ready_chan_b_n
);
  logic any_sel;

  assign any_sel = !(chan_a_select_n && chan_b_select_n);

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // host strobes are three cycles low, then released
  sequence s_rd_low;
    !read_strobe_n [*3] ##1 read_strobe_n;
  endsequence
  sequence s_wr_low;
    !write_strobe_n [*3] ##1 write_strobe_n;
  endsequence

  a_oe_needs_read: assert property (data_d2h_oe |->
    !read_strobe_n && any_sel && $past(!read_strobe_n))
    else $error("device drives the bus outside a selected read");
  a_read_answer: assert property ($fell(read_strobe_n) && any_sel |=>
    read_strobe_n || !any_sel || data_d2h_oe)
    else $error("read byte not placed on the bus");
  a_read_stable: assert property (data_d2h_oe && $past(data_d2h_oe) |-> $stable(data_d2h))
    else $error("read byte changed while driven");
  a_no_contention: assert property (data_d2h_oe |-> !data_h2d_oe)
    else $error("both ends drive the data bus");
  a_rd_strobe_held: assert property ($fell(read_strobe_n) |-> any_sel throughout s_rd_low)
    else $error("read strobe width or select wrong");
  a_wr_data_held: assert property ($fell(write_strobe_n) |->
    (data_h2d_oe && any_sel) throughout s_wr_low)
    else $error("write byte not held across the strobe");
  a_one_select: assert property (!chan_a_select_n |-> chan_b_select_n)
    else $error("both channel selects low");
  a_gp_irq_pair: assert property (gp_out2_chan_a_n == !irq_chan_a_oe &&
    gp_out2_chan_b_n == !irq_chan_b_oe)
    else $error("port 2 pin disagrees with interrupt drive");
  a_reset_irq_off: assert property ($fell(rst_i) |-> !irq_chan_a_oe && !irq_chan_b_oe)
    else $error("interrupt driven after reset");
  a_reset_ready: assert property ($fell(rst_i) |-> !tx_ready_chan_a_n &&
    !tx_ready_chan_b_n && rx_ready_chan_a_n && rx_ready_chan_b_n)
    else $error("ready pins wrong after reset");
endmodule : duhbp_assertions

// [tb/test_duhbp.sv]
`timescale 1ns/10ps
module test_duhbp;
  logic            mclk_i;
  logic            rst_i;
  logic            req;
  logic            we;
  logic            chan;
  logic [2:0]      addr;
  logic [7:0]      wdata;
  logic            busy;
  logic            done;
  logic [7:0]      rdata;
  logic [1:0][7:0] tx_data;
  logic [1:0]      tx_valid;
  logic [1:0]      tx_rdy;
  logic [1:0][7:0] rx_data;
  logic [1:0]      rx_valid;
  logic [1:0]      rx_rdy;
  logic [7:0]      pins;
  int              fail_count;
  int              cmp_count;

  duhbp_if bus ();

  // irq a, irq b, port2 a, port2 b, tx ready a, b, rx ready a, b
  assign pins = {bus.irq_out_chan_a, bus.irq_out_chan_b, bus.gp_out2_chan_a_n,
    bus.gp_out2_chan_b_n, bus.tx_ready_chan_a_n, bus.tx_ready_chan_b_n,
    bus.rx_ready_chan_a_n, bus.rx_ready_chan_b_n};

  duhbp_device i_duhbp_device (
    .mclk_i(mclk_i), .rst_i(rst_i), .bus(bus), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .tx_ready_i(tx_rdy), .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_rdy));
  duhbp_host i_duhbp_host (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .we_i(we), .chan_i(chan), .addr_i(addr),
    .wdata_i(wdata), .busy_o(busy), .done_o(done), .rdata_o(rdata), .bus(bus));
  duhbp_assertions i_duhbp_assertions (
    .mclk_i(mclk_i), .rst_i(rst_i), .data_d2h(bus.data_d2h), .data_d2h_oe(bus.data_d2h_oe),
    .data_h2d_oe(bus.data_h2d_oe), .chan_a_select_n(bus.chan_a_select_n),
    .chan_b_select_n(bus.chan_b_select_n), .read_strobe_n(bus.read_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .irq_chan_a_oe(bus.irq_chan_a_oe),
    .irq_chan_b_oe(bus.irq_chan_b_oe), .gp_out2_chan_a_n(bus.gp_out2_chan_a_n),
    .gp_out2_chan_b_n(bus.gp_out2_chan_b_n), .tx_ready_chan_a_n(bus.tx_ready_chan_a_n),
    .tx_ready_chan_b_n(bus.tx_ready_chan_b_n), .rx_ready_chan_a_n(bus.rx_ready_chan_a_n),
    .rx_ready_chan_b_n(bus.rx_ready_chan_b_n));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task finish_test;
    $display("compares %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one host command, done expected within a bounded wait
  task automatic op(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
    int n;
    @(negedge mclk_i);
    req = 1'b1;
    we = w;
    chan = c;
    addr = a;
    wdata = d;
    @(negedge mclk_i);
    req = 1'b0;
    chk({7'h00, busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      finish_test();
    end
    chk({6'h00, busy, done}, 8'h01);
    // setup, three strobe cycles, recovery
    chk(8'(n), 8'h05);
  endtask : op

  task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
    op(1'b1, c, a, d);
  endtask : wr

  task automatic rd(input logic c, input logic [2:0] a, input logic [7:0] e);
    op(1'b0, c, a, 8'h00);
    chk(rdata, e);
  endtask : rd

  task s_reset;
    chk(pins, 8'h33);
    chk(bus.data, 8'hFF);
    chk({4'h0, tx_valid, rx_rdy}, 8'h03);
    rd(1'b0, 3'h4, 8'h00);
    rd(1'b0, 3'h5, 8'h60);
  endtask : s_reset

  task s_regs;
    wr(1'b0, 3'h7, 8'h5A);
    wr(1'b1, 3'h7, 8'hA5);
    rd(1'b0, 3'h7, 8'h5A);
    rd(1'b1, 3'h7, 8'hA5);
    rd(1'b0, 3'h6, 8'h00);
    wr(1'b0, 3'h4, 8'h08);
    rd(1'b0, 3'h4, 8'h08);
    rd(1'b1, 3'h4, 8'h00);
    chk(pins, 8'h13);
  endtask : s_regs

  task s_irq;
    wr(1'b0, 3'h1, 8'h02);
    repeat (2) @(negedge mclk_i);
    chk(pins, 8'h93);
    wr(1'b0, 3'h4, 8'h00);
    repeat (2) @(negedge mclk_i);
    chk(pins, 8'h33);
    wr(1'b0, 3'h1, 8'h00);
  endtask : s_irq

  // one byte past full must be dropped
  task s_tx;
    int i;
    for (i = 0; i < 65; i++)
      wr(1'b0, 3'h0, 8'(i));
    repeat (2) @(negedge mclk_i);
    chk(pins, 8'h3B);
    chk({4'h0, tx_valid, rx_rdy}, 8'h07);
    rd(1'b0, 3'h2, 8'h40);
    rd(1'b0, 3'h5, 8'h00);
    tx_rdy = 2'h1;
    for (i = 0; i < 70 && tx_valid[0] === 1'b1; i++) begin
      chk(tx_data[0], 8'(i));
      @(negedge mclk_i);
    end
    tx_rdy = 2'h0;
    chk(8'(i), 8'h40);
    repeat (2) @(negedge mclk_i);
    chk(pins, 8'h33);
  endtask : s_tx

  task s_rx;
    int i;
    rx_valid = 2'h2;
    for (i = 0; i < 65; i++) begin
      rx_data[1] = 8'(i);
      @(negedge mclk_i);
    end
    rx_valid = 2'h0;
    chk({7'h00, rx_rdy[1]}, 8'h00);
    repeat (2) @(negedge mclk_i);
    chk(pins, 8'h32);
    rd(1'b1, 3'h3, 8'h40);
    rd(1'b1, 3'h5, 8'h61);
    wr(1'b1, 3'h1, 8'h01);
    wr(1'b1, 3'h4, 8'h08);
    repeat (2) @(negedge mclk_i);
    chk(pins, 8'h62);
    rd(1'b1, 3'h1, 8'h01);
    wr(1'b1, 3'h4, 8'h00);
    wr(1'b1, 3'h1, 8'h00);
    rd(1'b0, 3'h3, 8'h00);
    for (i = 0; i < 64; i++)
      rd(1'b1, 3'h0, 8'(i));
    rd(1'b1, 3'h0, 8'h00);
    repeat (2) @(negedge mclk_i);
    chk(pins, 8'h33);
    wr(1'b1, 3'h0, 8'hC3);
    chk(tx_data[1], 8'hC3);
    chk({6'h00, tx_valid}, 8'h02);
    tx_rdy = 2'h2;
    @(negedge mclk_i);
    tx_rdy = 2'h0;
    chk({6'h00, tx_valid}, 8'h00);
  endtask : s_rx

  initial begin
    fail_count = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    chan = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    tx_rdy = 2'h0;
    rx_data = 16'h0000;
    rx_valid = 2'h0;
    repeat (8) @(negedge mclk_i);
    rst_i = 1'b0;
    s_reset();
    s_regs();
    s_irq();
    s_tx();
    s_rx();
    finish_test();
  end
endmodule : test_duhbp
